/* File: cc_timer_pkg.sv */
package cc_timer_pkg;

    // Register indices (printed offsets are not all word multiples; byte address = 4 * index)
    localparam logic [7:0] IDX_DIRECTION   = 8'hc0;
    localparam logic [7:0] IDX_FORCE       = 8'hc1;
    localparam logic [7:0] IDX_MASK3       = 8'hc2;
    localparam logic [7:0] IDX_DATA3       = 8'hc3;
    localparam logic [7:0] IDX_COUNTER     = 8'hc4;
    localparam logic [7:0] IDX_CONTROL1    = 8'hc6;
    localparam logic [7:0] IDX_OUT_CTRL    = 8'hc8;
    localparam logic [7:0] IDX_EDGE_CTRL   = 8'hc9;
    localparam logic [7:0] IDX_IRQ_ENABLE  = 8'hca;
    localparam logic [7:0] IDX_SYS_CTRL2   = 8'hcb;
    localparam logic [7:0] IDX_FLAG1       = 8'hcc;
    localparam logic [7:0] IDX_FLAG2       = 8'hcd;
    localparam logic [7:0] IDX_VALUE0      = 8'hce;
    localparam logic [7:0] IDX_VALUE1      = 8'hd0;
    localparam logic [7:0] IDX_VALUE2      = 8'hd2;
    localparam logic [7:0] IDX_VALUE3      = 8'hd4;
    localparam logic [7:0] IDX_PORT_DATA   = 8'hd6;

    // Field positions
    localparam int CTRL1_FAST_CLEAR_BIT = 4;
    localparam int SYS2_OVF_IRQ_BIT     = 7;
    localparam int SYS2_CNT_RESET_BIT   = 3;
    localparam int FLAG2_OVF_BIT        = 7;

    // Reset values
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [7:0]  REG8_RESET  = 8'h00;

    localparam int CHANNELS = 4;

    typedef struct packed {
        logic        overflowIrqEnable;
        logic        counterResetOnMatch3;
        logic [2:0]  prescaleSelect;
    } sys_ctrl_t;

    typedef struct packed {
        logic [3:0] channelIrq;
        logic       overflowIrq;
    } irq_bundle_t;

endpackage

/* File: cc_timer.sv */
`timescale 1ns/10ps

module cc_timer #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      clkEn,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]         address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic      [31:0]               readdata,
    output logic                           waitrequest,
    // Channel pins
    input  wire logic [3:0]                pinIn,
    output logic      [3:0]                pinOut,
    output logic      [3:0]                pinOe,
    // Interrupt requests
    output cc_timer_pkg::irq_bundle_t      irqReq
);

    if (ADDR_W < 10) begin : gAddrCheck
        $error("ADDR_W must reach register index 0xd6");
    end

    logic [7:0]  dirReg_r;
    logic [7:0]  mask3_r;
    logic [7:0]  data3_r;
    logic [7:0]  ctrl1_r;
    logic [7:0]  irqEn_r;
    logic [7:0]  edgeLo_r;
    logic [7:0]  edgeHi_r;
    logic [7:0]  outCtrl_r;
    logic [7:0]  portLatch_r;
    cc_timer_pkg::sys_ctrl_t sys_r;
    logic [3:0]  flag_r;
    logic        ovf_r;
    logic [15:0] counter_r;
    logic [15:0] value_r [cc_timer_pkg::CHANNELS];
    logic [6:0]  pre_r;
    logic [2:0]  preSel_r;
    logic [3:0]  pinState_r;
    logic        ack_r;

    // Bus: one wait state, so the answer stands at the second edge of the request
    // Writes commit on the request edge; the wait state only lets read data settle
    logic        acc, wrAcc, rdAcc;
    logic [7:0]  idx;
    assign acc   = (read | write) & ~ack_r & clkEn;
    assign wrAcc = write & acc;
    assign rdAcc = read & acc;
    assign idx   = address[ADDR_W-1:2] > 8'hff ? 8'hff : 8'(address[ADDR_W-1:2]);
    assign waitrequest = (read | write) & ~ack_r;

    function automatic int chanOf(input logic [7:0] i);
        unique case (i)
            cc_timer_pkg::IDX_VALUE0: chanOf = 0;
            cc_timer_pkg::IDX_VALUE1: chanOf = 1;
            cc_timer_pkg::IDX_VALUE2: chanOf = 2;
            cc_timer_pkg::IDX_VALUE3: chanOf = 3;
            default:                  chanOf = -1;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) ack_r <= 1'b0;
        else if (clkEn) ack_r <= (read | write) & ~ack_r;
    end

    // Pin synchroniser: three stages, change counts when stages two and three agree
    logic [3:0] s1_r, s2_r, s3_r, pinStable_r, pinPrev_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 4'h0; s2_r <= 4'h0; s3_r <= 4'h0; pinStable_r <= 4'h0; pinPrev_r <= 4'h0;
        end else if (clkEn) begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pinStable_r <= (s2_r & s3_r) | (pinStable_r & (s2_r | s3_r));
            pinPrev_r   <= pinStable_r;
        end
    end

    // Edge detection per channel
    logic [3:0] capEv;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gEdge
            logic rise, fall;
            assign rise = pinStable_r[g] & ~pinPrev_r[g];
            assign fall = ~pinStable_r[g] & pinPrev_r[g];
            assign capEv[g] = ~dirReg_r[g] &
                ((edgeLo_r[g] & rise) | (edgeHi_r[g] & fall));
        end
    endgenerate

    // Prescaler: select reloaded on a tick (selected low stages zero) or when pre_r reaches 7f
    logic tick;
    assign tick = (pre_r & ((7'h01 << preSel_r) - 7'h01)) == 7'h00;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r    <= 7'h00;
            preSel_r <= 3'h0;
        end else if (clkEn) begin
            pre_r <= pre_r + 7'h01;
            if (pre_r == 7'h7f || preSel_r == 3'h0 || tick) begin
                if (pre_r == 7'h7f || tick) pre_r <= 7'h00;
                preSel_r <= sys_r.prescaleSelect;
                if (tick && preSel_r != 3'h0) pre_r <= 7'h01;
                if (preSel_r == 3'h0) pre_r <= 7'h00;
            end
        end
    end

    // Compare matches
    logic [3:0] match;
    generate
        for (g = 0; g < 4; g++) begin : gMatch
            assign match[g] = dirReg_r[g] & tick & (counter_r == value_r[g]);
        end
    endgenerate

    // Counter
    logic cntReset3;
    // Only a genuine compare on channel 3 may clear the counter, never a capture
    assign cntReset3 = sys_r.counterResetOnMatch3 & match[3];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) counter_r <= 16'h0000;
        else if (clkEn) begin
            if (wrAcc && idx == cc_timer_pkg::IDX_COUNTER) counter_r <= writedata[15:0];
            else if (cntReset3) counter_r <= 16'h0000;
            else if (tick) counter_r <= counter_r + 16'h0001;
        end
    end

    // Compare pin actions; channel 3 applied last so it overrides masked pins
    logic [7:0] forceW;
    assign forceW = (wrAcc && idx == cc_timer_pkg::IDX_FORCE) ? writedata[7:0] : 8'h00;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) pinState_r <= 4'h0;
        else if (clkEn) begin
            for (int c = 0; c < 4; c++) begin
                if ((match[c] | forceW[c]) && dirReg_r[c]) begin
                    unique case ({outCtrl_r[2*c+1], outCtrl_r[2*c]})
                        2'b01: pinState_r[c] <= ~pinState_r[c];
                        2'b10: pinState_r[c] <= 1'b0;
                        2'b11: pinState_r[c] <= 1'b1;
                        default: ;
                    endcase
                end
            end
            if (match[3] | forceW[3]) begin
                for (int c = 0; c < 4; c++) begin
                    if (mask3_r[c]) pinState_r[c] <= data3_r[c];
                end
            end
        end
    end

    // Pin drive: compare owns the pin when its action is selected or mask3 covers it, else port latch
    generate
        for (g = 0; g < 4; g++) begin : gPin
            logic owned;
            assign owned = (dirReg_r[g] & (outCtrl_r[2*g] | outCtrl_r[2*g+1])) | mask3_r[g];
            assign pinOut[g] = owned ? pinState_r[g] : portLatch_r[g];
            assign pinOe[g]  = owned | dirReg_r[g];
        end
    endgenerate

    // Control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dirReg_r <= 8'h00; mask3_r <= 8'h00; data3_r <= 8'h00; ctrl1_r <= 8'h00;
            irqEn_r <= 8'h00; edgeLo_r <= 8'h00; edgeHi_r <= 8'h00; outCtrl_r <= 8'h00;
            portLatch_r <= 8'h00; sys_r <= '0;
        end else if (clkEn && wrAcc && byteenable[0]) begin
            unique case (idx)
                cc_timer_pkg::IDX_DIRECTION:  dirReg_r    <= {4'h0, writedata[3:0]};
                cc_timer_pkg::IDX_MASK3:      mask3_r     <= {4'h0, writedata[3:0]};
                cc_timer_pkg::IDX_DATA3:      data3_r     <= {4'h0, writedata[3:0]};
                cc_timer_pkg::IDX_CONTROL1:   ctrl1_r     <= writedata[7:0];
                cc_timer_pkg::IDX_IRQ_ENABLE: irqEn_r     <= {4'h0, writedata[3:0]};
                cc_timer_pkg::IDX_OUT_CTRL:   outCtrl_r   <= writedata[7:0];
                cc_timer_pkg::IDX_PORT_DATA:  portLatch_r <= {4'h0, writedata[3:0]};
                cc_timer_pkg::IDX_EDGE_CTRL: begin
                    for (int c = 0; c < 4; c++) begin
                        edgeLo_r[c] <= writedata[2*c];
                        edgeHi_r[c] <= writedata[2*c+1];
                    end
                end
                cc_timer_pkg::IDX_SYS_CTRL2: begin
                    sys_r.overflowIrqEnable    <= writedata[cc_timer_pkg::SYS2_OVF_IRQ_BIT];
                    sys_r.counterResetOnMatch3 <= writedata[cc_timer_pkg::SYS2_CNT_RESET_BIT];
                    sys_r.prescaleSelect       <= writedata[2:0];
                end
                default: ;
            endcase
        end
    end

    // Value registers: capture wins over a same-cycle software write
    logic fastClr;
    assign fastClr = ctrl1_r[cc_timer_pkg::CTRL1_FAST_CLEAR_BIT];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < 4; c++) value_r[c] <= cc_timer_pkg::VALUE_RESET;
        end else if (clkEn) begin
            for (int c = 0; c < 4; c++) begin
                if (capEv[c]) value_r[c] <= counter_r;
                else if (wrAcc && chanOf(idx) == c && dirReg_r[c]) begin
                    if (byteenable[1]) value_r[c][15:8] <= writedata[15:8];
                    if (byteenable[0]) value_r[c][7:0]  <= writedata[7:0];
                end
            end
        end
    end

    // Flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 4'h0;
            ovf_r  <= 1'b0;
        end else if (clkEn) begin
            for (int c = 0; c < 4; c++) begin
                if (capEv[c] | match[c]) flag_r[c] <= 1'b1;
                else if (wrAcc && idx == cc_timer_pkg::IDX_FLAG1 && writedata[c])
                    flag_r[c] <= 1'b0;
                else if (fastClr && chanOf(idx) == c &&
                         ((rdAcc && !dirReg_r[c]) || (wrAcc && dirReg_r[c])))
                    flag_r[c] <= 1'b0;
            end
            if (tick && counter_r == 16'hffff && !cntReset3) ovf_r <= 1'b1;
            else if (wrAcc && idx == cc_timer_pkg::IDX_FLAG2 &&
                     writedata[cc_timer_pkg::FLAG2_OVF_BIT]) ovf_r <= 1'b0;
            else if (fastClr && acc && idx == cc_timer_pkg::IDX_COUNTER) ovf_r <= 1'b0;
        end
    end

    // Interrupt requests
    assign irqReq.channelIrq  = flag_r & irqEn_r[3:0];
    assign irqReq.overflowIrq = ovf_r & sys_r.overflowIrqEnable;

    // Read data, latched on the request edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) readdata <= 32'h0000_0000;
        else if (clkEn && rdAcc) begin
            readdata <= 32'h0000_0000;
            unique case (idx)
                cc_timer_pkg::IDX_DIRECTION:  readdata[7:0] <= dirReg_r;
                cc_timer_pkg::IDX_FORCE:      readdata[7:0] <= 8'h00;   // Strobes only
                cc_timer_pkg::IDX_MASK3:      readdata[7:0] <= mask3_r;
                cc_timer_pkg::IDX_DATA3:      readdata[7:0] <= data3_r;
                cc_timer_pkg::IDX_COUNTER:    readdata[15:0] <= counter_r;
                cc_timer_pkg::IDX_CONTROL1:   readdata[7:0] <= ctrl1_r;
                cc_timer_pkg::IDX_OUT_CTRL:   readdata[7:0] <= outCtrl_r;
                cc_timer_pkg::IDX_EDGE_CTRL:
                    readdata[7:0] <= {edgeHi_r[3], edgeLo_r[3], edgeHi_r[2], edgeLo_r[2],
                                      edgeHi_r[1], edgeLo_r[1], edgeHi_r[0], edgeLo_r[0]};
                cc_timer_pkg::IDX_IRQ_ENABLE: readdata[7:0] <= irqEn_r;
                cc_timer_pkg::IDX_SYS_CTRL2:
                    readdata[7:0] <= {sys_r.overflowIrqEnable, 3'h0,
                                      sys_r.counterResetOnMatch3, sys_r.prescaleSelect};
                cc_timer_pkg::IDX_FLAG1:      readdata[7:0] <= {4'h0, flag_r};
                cc_timer_pkg::IDX_FLAG2:      readdata[7:0] <= {ovf_r, 7'h00};
                cc_timer_pkg::IDX_VALUE0:     readdata[15:0] <= value_r[0];
                cc_timer_pkg::IDX_VALUE1:     readdata[15:0] <= value_r[1];
                cc_timer_pkg::IDX_VALUE2:     readdata[15:0] <= value_r[2];
                cc_timer_pkg::IDX_VALUE3:     readdata[15:0] <= value_r[3];
                cc_timer_pkg::IDX_PORT_DATA:  readdata[7:0] <= portLatch_r;
                default: ;
            endcase
        end
    end

endmodule // cc_timer

/* File: pin_partner.sv */
`timescale 1ns/10ps
module pin_partner (
    // Clock
    input  wire logic       mclk,
    // Device side of the pins
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOe,
    output logic      [3:0] pinIn
);
    logic [3:0] extLvl = 4'h0;

    // A driven pin shows the device level; an undriven one the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);

    // Pulses stay longer than two clocks so the edge detector sees them
    task automatic pulse(input int ch, input int len);
        @(posedge mclk);
        extLvl[ch] <= 1'b1;
        repeat (len) @(posedge mclk);
        extLvl[ch] <= 1'b0;
    endtask
endmodule // pin_partner

/* File: cc_timer_props.sv */
`timescale 1ns/10ps
module cc_timer_props #(
    parameter int ADDR_W = 10
) (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire logic                      clkEn,
    input wire logic [ADDR_W-1:0]         address,
    input wire logic                      read,
    input wire logic                      write,
    input wire logic [31:0]               writedata,
    input wire logic [3:0]                byteenable,
    input wire logic [31:0]               readdata,
    input wire logic                      waitrequest,
    input wire logic [3:0]                pinIn,
    input wire logic [3:0]                pinOut,
    input wire logic [3:0]                pinOe,
    input wire cc_timer_pkg::irq_bundle_t irqReq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wait_idle: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest raised without a request");
    a_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("request answered without the wait state");
    a_wait_once: assert property ((read || write) && waitrequest && clkEn |=> !waitrequest)
        else $error("more than one wait state");
    a_data_hold: assert property (read && !waitrequest |=> $stable(readdata))
        else $error("read data moved after the answer");
    a_data_idle: assert property (!$past(read) |-> $stable(readdata))
        else $error("read data changed with no read");
    a_irq_reset: assert property ($rose(rst_n) |-> irqReq == 5'h00)
        else $error("interrupt request active out of reset");
    a_irq_fall: assert property (|($past(irqReq) & ~irqReq)
        |-> $past(read || write))
        else $error("interrupt request dropped without a bus access");
    a_oe_cause: assert property ($changed(pinOe) |-> $past(write))
        else $error("pin enable changed without a register write");
endmodule // cc_timer_props

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
    localparam int ADDR_W = 10;
    logic mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic [31:0] writedata = '0, readdata, rv;
    logic [3:0] byteenable = 4'h0, pinIn, pinOut, pinOe;
    logic waitrequest;
    cc_timer_pkg::irq_bundle_t irqReq;
    int fails = 0, num_checks = 0;
    logic [7:0] valIdx [4] = '{8'hce, 8'hd0, 8'hd2, 8'hd4};

    always #25 mclk = ~mclk;

    cc_timer #(.ADDR_W(ADDR_W)) dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
    pin_partner p (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] be = 4'h3);
        @(posedge mclk);
        address <= {idx, 2'b00};
        writedata <= {16'h0000, d};
        byteenable <= be;
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge mclk);
        address <= {idx, 2'b00};
        byteenable <= 4'h3;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rv = readdata;
        read <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkr(input string n, input logic [15:0] lo, input logic [15:0] hi,
                        input logic [15:0] g);
        num_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            fails++;
            $display("MISMATCH %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Window edges for a capture started about six clocks after the counter write
    logic [15:0] lo [4] = '{16'h0000, 16'h1002, 16'h1016, 16'h1016};
    logic [15:0] hi [4] = '{16'h0000, 16'h100c, 16'h1020, 16'h1020};

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (valIdx[i]) begin
            rd(valIdx[i]); chk("value reset", 32'h0, rv);
        end
        rd(8'hc7); chk("unmapped read", 32'h0, rv);
        wr(8'hce, 16'h1234); rd(8'hce); chk("capture-mode write", 32'h0, rv);
        $display("test registers done");
        wr(8'hc0, 16'h0001);
        wr(8'hce, 16'h0000, 4'h2); wr(8'hce, 16'h0040, 4'h1);
        rd(8'hce); chk("compare-mode write", 32'h40, rv);
        wr(8'hc8, 16'h0003); wr(8'hc4, 16'h0000);
        repeat (100) @(posedge mclk);
        chk("pin set on match", 32'h1, {31'h0, pinOut[0] & pinOe[0]});
        chk("masked channel irq", 32'h0, {31'h0, irqReq.channelIrq[0]});
        rd(8'hcc); chk("compare flag", 32'h1, rv & 32'h1);
        wr(8'hca, 16'h0001); chk("channel irq", 32'h1, {31'h0, irqReq.channelIrq[0]});
        wr(8'hcc, 16'h0000); chk("zero write keeps flag", 32'h1, {31'h0, irqReq.channelIrq[0]});
        wr(8'hcc, 16'h0001); chk("flag cleared", 32'h0, {31'h0, irqReq.channelIrq[0]});
        wr(8'hc8, 16'h0002); wr(8'hc1, 16'h0001);
        chk("forced clear", 32'h0, {31'h0, pinOut[0]});
        rd(8'hcc); chk("force sets no flag", 32'h0, rv & 32'h1);
        wr(8'hd6, 16'h0001); chk("latch only", 32'h0, {31'h0, pinOut[0]});
        $display("test compare done");
        wr(8'hc0, 16'h0000); wr(8'hca, 16'h0002);
        for (int m = 0; m < 4; m++) begin
            wr(8'hc9, 16'(m << 2)); wr(8'hc4, 16'h1000);
            p.pulse(1, 20);
            repeat (10) @(posedge mclk);
            rd(8'hd0); chkr("captured value", lo[m], hi[m], rv[15:0]);
            chk("capture irq", {31'h0, m != 0}, {31'h0, irqReq.channelIrq[1]});
            wr(8'hcc, 16'h0002);
            if (m != 0) wr(8'hd0, 16'h0000);
        end
        $display("test capture done");
        wr(8'hcb, 16'h0080); wr(8'hc4, 16'hfff0);
        repeat (30) @(posedge mclk);
        chk("overflow irq", 32'h1, {31'h0, irqReq.overflowIrq});
        wr(8'hcd, 16'h0080); chk("overflow cleared", 32'h0, {31'h0, irqReq.overflowIrq});
        wr(8'hc0, 16'h0008); wr(8'hd4, 16'h0000); wr(8'hcb, 16'h0008); wr(8'hc4, 16'h0000);
        wr(8'hc2, 16'h0001); wr(8'hc3, 16'h0001);
        repeat (20) @(posedge mclk);
        rd(8'hc4); chk("counter held", 32'h0, rv & 32'hffff);
        chk("channel 3 override", 32'h1, {31'h0, pinOut[0] & pinOe[0]});
        wr(8'hd4, 16'h0010);
        repeat (60) @(posedge mclk);
        rd(8'hc4); chkr("counter modulus", 16'h0000, 16'h0010, rv[15:0]);
        wr(8'hcb, 16'h0007); wr(8'hc4, 16'h0000);
        repeat (640) @(posedge mclk);
        rd(8'hc4); chkr("divided count", 16'h0003, 16'h0005, rv[15:0]);
        $display("test counter done");
        conclude();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule // testbench

bind cc_timer cc_timer_props #(.ADDR_W(ADDR_W)) u_props (.mclk(mclk), .rst_n(rst_n),
    .clkEn(clkEn), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
